// ===== verilog/eel_ctrl.sv
// edge event line controller with axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
// Operation
// - nineteen lines raising interrupt or event requests
// - rising, falling or both edges per line
// - per-line mask blocks processor request only
// - pending bit records selected edge per line
// - single-cycle pulses are still caught
// - sixteen lines selected from fifty-one pins
// - other lines: level detector, alarm, bus wakeup
// - trigger drives wakeup without a clocked stage
module eel_ctrl
    import eel_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [50:0] pins,
    input  wire logic        supply_level_detector,
    input  wire logic        rtc_alarm,
    input  wire logic        bus_wakeup,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             irq,
    output logic             wake,
    output logic [18:0]      event_out
);
    eel_cfg_s    cfg;
    logic [5:0]  sel [EEL_PIN_LN];
    logic [18:0] line_in;
    logic [18:0] prev;
    logic [18:0] hit;
    logic [18:0] pending;
    logic [18:0] clr;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  wa;
    logic [31:0] w_d;
    logic [3:0]  w_s;
    logic [31:0] wbm;
    logic        wr_go;
    logic        wr_sel [EEL_SEL_REGS];
    logic        wr_map;
    logic        rd_map;
    logic [31:0] sel_word [EEL_SEL_REGS];
    logic [31:0] rd_word;
    logic        ar_go;

    // pin selector for the first sixteen lines
    genvar g;
    generate
        for (g = 0; g < EEL_PIN_LN; g++) begin : g_pin
            assign line_in[g] = (sel[g] <= EEL_PIN_LAST) ? pins[sel[g]] : 1'b0;
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sel[g] <= RST_SEL;
                end else if (wr_sel[g / 4] && w_s[g % 4]) begin
                    sel[g] <= w_d[8 * (g % 4) +: 6];
                end
            end
        end
        for (g = 0; g < EEL_SEL_REGS; g++) begin : g_selw
            assign sel_word[g] = {2'h0, sel[4*g+3], 2'h0, sel[4*g+2], 2'h0, sel[4*g+1], 2'h0, sel[4*g]};
        end
    endgenerate

    assign line_in[EEL_LN_SLD]   = supply_level_detector;
    assign line_in[EEL_LN_ALARM] = rtc_alarm;
    assign line_in[EEL_LN_BUSWK] = bus_wakeup;

    assign hit = (line_in & ~prev & cfg.rise) | (~line_in & prev & cfg.fall);

    // write channel decode
    assign awready = ~aw_held;
    assign wready  = ~w_held;
    assign wr_go   = aw_held & w_held & ~bvalid;
    assign wbm     = {{8{w_s[3]}}, {8{w_s[2]}}, {8{w_s[1]}}, {8{w_s[0]}}};
    assign wr_sel[0] = wr_go && (wa == OFS_SEL0);
    assign wr_sel[1] = wr_go && (wa == OFS_SEL1);
    assign wr_sel[2] = wr_go && (wa == OFS_SEL2);
    assign wr_sel[3] = wr_go && (wa == OFS_SEL3);
    assign wr_map  = (wa == OFS_IMASK) || (wa == OFS_EMASK) || (wa == OFS_RISE) || (wa == OFS_FALL)
                     || (wa == OFS_PEND) || (wa == OFS_SEL0) || (wa == OFS_SEL1) || (wa == OFS_SEL2)
                     || (wa == OFS_SEL3);
    assign clr     = (wr_go && (wa == OFS_PEND)) ? (w_d[18:0] & wbm[18:0]) : RST_LINES;

    // read decode
    assign arready = ~rvalid;
    assign ar_go   = arvalid & ~rvalid;
    assign rd_word = (araddr == OFS_IMASK) ? {13'h0, cfg.imask} :
                     (araddr == OFS_EMASK) ? {13'h0, cfg.emask} :
                     (araddr == OFS_RISE)  ? {13'h0, cfg.rise}  :
                     (araddr == OFS_FALL)  ? {13'h0, cfg.fall}  :
                     (araddr == OFS_PEND)  ? {13'h0, pending}   :
                     (araddr == OFS_SEL0)  ? sel_word[0]        :
                     (araddr == OFS_SEL1)  ? sel_word[1]        :
                     (araddr == OFS_SEL2)  ? sel_word[2]        :
                     (araddr == OFS_SEL3)  ? sel_word[3]        : 32'h0;
    assign rd_map  = (araddr == OFS_IMASK) || (araddr == OFS_EMASK) || (araddr == OFS_RISE)
                     || (araddr == OFS_FALL) || (araddr == OFS_PEND) || (araddr == OFS_SEL0)
                     || (araddr == OFS_SEL1) || (araddr == OFS_SEL2) || (araddr == OFS_SEL3);

    assign irq  = |(pending & cfg.imask);
    assign wake = irq | (|(hit & (cfg.imask | cfg.emask)));

    // axi write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            wa      <= 8'h00;
            w_d     <= 32'h0;
            w_s     <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                wa      <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                w_d    <= wdata;
                w_s    <= wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // axi read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= RESP_OKAY;
        end else if (ar_go) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg <= {RST_LINES, RST_LINES, RST_LINES, RST_LINES};
        end else if (wr_go) begin
            if (wa == OFS_RISE)  cfg.rise  <= (cfg.rise  & ~wbm[18:0]) | (w_d[18:0] & wbm[18:0]);
            if (wa == OFS_FALL)  cfg.fall  <= (cfg.fall  & ~wbm[18:0]) | (w_d[18:0] & wbm[18:0]);
            if (wa == OFS_IMASK) cfg.imask <= (cfg.imask & ~wbm[18:0]) | (w_d[18:0] & wbm[18:0]);
            if (wa == OFS_EMASK) cfg.emask <= (cfg.emask & ~wbm[18:0]) | (w_d[18:0] & wbm[18:0]);
        end
    end

    // edge capture, pending and event pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev      <= RST_LINES;
            pending   <= RST_LINES;
            event_out <= RST_LINES;
        end else begin
            prev      <= line_in;
            pending   <= (pending & ~clr) | hit;
            event_out <= hit & cfg.emask;
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_event;
        |hit |=> event_out == $past(hit & cfg.emask);
    endproperty
    a_event: assert property (p_event) else $error("event pulse wrong");

    property p_rise_only;
        |(~line_in & prev & ~cfg.fall) |=> (event_out & $past(~line_in & prev & ~cfg.fall)) == RST_LINES;
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("fall counted with rise only");

    property p_mask;
        (cfg.imask == RST_LINES) |-> !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("masked line raised irq");

    property p_pend_set;
        |hit |=> (pending & $past(hit)) == $past(hit);
    endproperty
    a_pend_set: assert property (p_pend_set) else $error("edge not recorded");

    property p_pulse;
        (line_in[0] && !prev[0] && cfg.rise[0]) ##1 !line_in[0] |-> pending[0];
    endproperty
    a_pulse: assert property (p_pulse) else $error("short pulse lost");

    property p_sel;
        wr_sel[0] && w_s[0] |=> sel[0] == $past(w_d[5:0]);
    endproperty
    a_sel: assert property (p_sel) else $error("pin select not stored");

    property p_alarm;
        $fell(rtc_alarm) && cfg.fall[EEL_LN_ALARM] |=> pending[EEL_LN_ALARM];
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm edge lost");

    property p_wake;
        |(hit & cfg.imask) |-> wake ##1 irq;
    endproperty
    a_wake: assert property (p_wake) else $error("no wakeup on trigger");

    property p_hold;
        irq && clr == RST_LINES && !(wr_go && wa == OFS_IMASK) |=> irq;
    endproperty
    a_hold: assert property (p_hold) else $error("pending dropped uncleared");

    c_write: cover property (wr_go && wr_map);
    c_clear: cover property (|clr ##1 !irq);
    c_both:  cover property (|(hit & cfg.rise & cfg.fall));
    c_read:  cover property (rvalid && rready && rdata != 32'h0);
endmodule
`default_nettype wire

// ===== shared/eel_pkg.sv
// constants and carrier types of the edge event line controller
package eel_pkg;
    localparam int          EEL_LINES    = 19;
    localparam int          EEL_PIN_LN   = 16;
    localparam int          EEL_PINS     = 51;
    localparam int          EEL_SEL_W    = 6;
    localparam int          EEL_SEL_REGS = 4;
    localparam logic [5:0]  EEL_PIN_LAST = 6'h32;
    localparam int          EEL_LN_SLD   = 16;
    localparam int          EEL_LN_ALARM = 17;
    localparam int          EEL_LN_BUSWK = 18;
    localparam logic [7:0]  OFS_IMASK    = 8'h00;
    localparam logic [7:0]  OFS_EMASK    = 8'h04;
    localparam logic [7:0]  OFS_RISE     = 8'h08;
    localparam logic [7:0]  OFS_FALL     = 8'h0c;
    localparam logic [7:0]  OFS_PEND     = 8'h10;
    localparam logic [7:0]  OFS_SEL0     = 8'h20;
    localparam logic [7:0]  OFS_SEL1     = 8'h24;
    localparam logic [7:0]  OFS_SEL2     = 8'h28;
    localparam logic [7:0]  OFS_SEL3     = 8'h2c;
    localparam logic [18:0] RST_LINES    = 19'h00000;
    localparam logic [5:0]  RST_SEL      = 6'h00;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic [18:0] rise;
        logic [18:0] fall;
        logic [18:0] imask;
        logic [18:0] emask;
    } eel_cfg_s;
endpackage

// ===== bench/eel_host_model.sv
// processor-side model counting event request pulses
`timescale 1ns/1ps
`default_nettype none
module eel_host_model (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [18:0] event_out,
    output logic      [7:0]  ev_seen
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_seen <= 8'h00;
        end else if (|event_out) begin
            ev_seen <= ev_seen + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ===== bench/eel_ctrl_bench.sv
// self-checking bench of the edge event line controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin chk_g = 64'(g); chk_e = 64'(e); num_checks++; if (chk_g !== chk_e) begin \
    failures++; $display("unexpected at %0t: got %h expected %h", $time, chk_g, chk_e); end end
module eel_ctrl_bench
    import eel_pkg::*;
;
    localparam logic [18:0] IM = 19'h00003;
    localparam logic [18:0] EM = 19'h5ffff;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        supply_level_detector = 1'b0, rtc_alarm = 1'b0, bus_wakeup = 1'b0;
    logic [50:0] pins = '0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'hf;
    logic        awready, wready, bvalid, arready, rvalid, irq, wake;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [18:0] event_out, pend = '0;
    logic [7:0]  ev_seen;
    logic [7:0]  ofs [6] = '{OFS_IMASK, OFS_EMASK, OFS_RISE, OFS_FALL, OFS_PEND, OFS_SEL0};
    logic [33:0] rq [$];
    logic [18:0] eq [$];
    logic [63:0] chk_g, chk_e;
    int          failures = 0, num_checks = 0, cyc = 0, n_ev = 0;
    int unsigned r0;

    eel_ctrl i_dut (.aclk, .aresetn, .pins, .supply_level_detector, .rtc_alarm, .bus_wakeup,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq, .wake, .event_out);
    eel_host_model i_host (.aclk, .aresetn, .event_out, .ev_seen);

    always #5 aclk = ~aclk;

    task automatic stop_test();
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc++;
        if (bvalid && bready) `CHK({bresp, 32'h0}, rq.pop_front())
        if (rvalid && rready) `CHK({rresp, rdata}, rq.pop_front())
        if (aresetn && event_out !== 19'h0) `CHK(event_out, eq.size() ? eq.pop_front() : 19'h7ffff)
        if (cyc == 3000) begin
            failures++;
            stop_test();
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        bit aw = 1'b1, w = 1'b1;
        rq.push_back({e, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            aw = aw & !awready;
            w = w & !wready;
            awvalid <= aw;
            wvalid <= w;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // pins pulse one cycle, internal sources held; pd is the pending set it causes
    task automatic step(input logic [50:0] p, input logic [2:0] s, input logic [18:0] pd, input logic w);
        pins <= p;
        {bus_wakeup, rtc_alarm, supply_level_detector} <= s;
        if (|(pd & EM)) eq.push_back(pd & EM);
        n_ev += int'(|(pd & EM));
        @(negedge aclk);
        `CHK(wake, w)
        pend |= pd;
        @(posedge aclk);
        pins <= '0;
        repeat (3) @(posedge aclk);
        `CHK(irq, |(pend & IM))
    endtask

    initial begin
        void'($urandom(32'hb73e95a6));
        r0 = $urandom % 50;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (ofs[i]) rd(ofs[i], {RESP_OKAY, 32'h0});
        rd(8'h40, {RESP_SLVERR, 32'h0});
        wr(8'h40, 32'h1, RESP_SLVERR);
        wr(OFS_SEL0, {8'h00, 8'h33, 8'h32, 2'b00, r0[5:0]}, RESP_OKAY);
        wr(OFS_RISE, 32'h00050005, RESP_OKAY);
        wr(OFS_FALL, 32'h00060002, RESP_OKAY);
        wstrb <= 4'h1;
        wr(OFS_FALL, 32'h00ff0002, RESP_OKAY);
        wstrb <= 4'hf;
        rd(OFS_FALL, {RESP_OKAY, 32'h00060002});
        wr(OFS_IMASK, {13'h0, IM}, RESP_OKAY);
        wr(OFS_EMASK, {13'h0, EM}, RESP_OKAY);
        rd(OFS_SEL0, {RESP_OKAY, 8'h00, 8'h33, 8'h32, 2'b00, r0[5:0]});
        rd(OFS_RISE, {RESP_OKAY, 32'h00050005});
        step('0, 3'b001, 19'h10000, 1'b1);
        step('0, 3'b011, 19'h00000, 1'b0);
        step('0, 3'b101, 19'h60000, 1'b1);
        step('0, 3'b000, 19'h40000, 1'b1);
        step(51'h1 << 50, 3'b000, 19'h00002, 1'b0);
        rd(OFS_PEND, {RESP_OKAY, 13'h0, pend});
        wr(OFS_PEND, 32'h2, RESP_OKAY);
        pend = pend & ~19'h2;
        step('0, 3'b000, 19'h0, 1'b0);
        step(51'h1 << r0, 3'b000, 19'h00001, 1'b1);
        rd(OFS_PEND, {RESP_OKAY, 13'h0, pend});
        wr(OFS_PEND, 32'hffffffff, RESP_OKAY);
        pend = '0;
        rd(OFS_PEND, {RESP_OKAY, 32'h0});
        step('0, 3'b000, 19'h0, 1'b0);
        `CHK(ev_seen, n_ev[7:0])
        stop_test();
    end
endmodule
`default_nettype wire
